// *** callerid_pkg.sv ***
package callerid_pkg;

  // Clock and timing figures
  localparam int CLOCK_HZ      = 250_000_000;
  localparam int CLOCK_NS      = 4;
  localparam int GAP_MS        = 40;
  localparam int GAP_CYCLES    = CLOCK_HZ / 1000 * GAP_MS;
  localparam int STROBE_NS     = 250;
  localparam int STROBE_CYCLES = (STROBE_NS + CLOCK_NS - 1) / CLOCK_NS;

  // Register map, byte addresses
  localparam logic [3:0]  CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]  STATUS_OFFSET = 4'h4;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam int          CTRL_EN_BIT   = 0;

  // Status register field positions
  localparam int ST_WINDOW  = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_PASS    = 2;
  localparam int ST_SUM_ERR = 3;
  localparam int ST_GAP_ERR = 4;
  localparam int ST_PKG_ERR = 5;
  localparam int ST_SUPPLY  = 6;
  localparam int ST_DETECT  = 7;

  // Message type nibbles, appended status words and serial unit widths in bits
  localparam logic [3:0] TYPE_MULTI  = 4'h8;
  localparam logic [3:0] TYPE_SINGLE = 4'h0;
  localparam logic [7:0] CHECK_PASS  = 8'hFF;
  localparam logic [7:0] CHECK_FAIL  = 8'h00;
  localparam logic [3:0] UNIT_HOST   = 4'h8;
  localparam logic [3:0] UNIT_DIALER = 4'h4;

  typedef enum {M_IDLE, M_LEN, M_PTYPE, M_PLEN, M_BODY, M_SUM, M_DRAIN, M_DONE} msg_state_t;

  // Upper nibble decides; lower nibble is ignored
  function automatic logic is_call_type(input logic [7:0] b);
    return (b[7:4] == TYPE_MULTI) || (b[7:4] == TYPE_SINGLE);
  endfunction

endpackage

// *** callerid_check.sv ***
// Function
// - Checking starts only after a valid type byte, with output window asserted low.
// - Check result appended last: full byte in host mode, nibble in dialer mode.
// - Status is all ones on pass; a failed check releases the window with no status appended.
// - Any check error releases the window and tri-states serial data at once.
// - Checksum error when running sum is nonzero after the checksum byte.
// - Error when demodulated bit holds 40 ms before checksum; later data dropped.
// - Multi-parameter message errs when last parameter misses the body end.
// - Supply-low detector enabled only during reversal, ring or external wake.
// - At end of wake event, latch detector result on flag on the same edge that disables detector.
// - Host mode only: irq pulses for new call and each byte boundary.
// - Valid call types have upper nibble 1000 or 0000.
// - Each irq pulse is exactly as long as a strobe pulse.
// - With strobe low at irq, strobe returns high before irq releases.
// - Serial data is high impedance whenever the output window is inactive.
// - All logic runs from one clock.
// - Output window released as soon as the final strobe pulse ends.
`timescale 1ns/1ps
module callerid_check
  import callerid_pkg::*;
#(
  parameter int GAP_LIMIT = GAP_CYCLES
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        dialer_mode,
  input  wire logic        ext_wake_n,
  input  wire logic        supply_low_sense,
  input  wire logic        serial_shift_clock,
  input  wire logic        ring_detect,
  input  wire logic        line_reversal,
  input  wire logic        demod_bit,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_byte_valid,
  output logic             serial_data_o,
  output logic             serial_data_oe_n,
  output logic             output_window_n_o,
  output logic             output_window_n_oe_n,
  output logic             byte_ready_strobe,
  output logic             host_irq_n_o,
  output logic             host_irq_n_oe_n,
  output logic             supply_low_flag,
  output logic             detector_enable
);

  localparam int GW = $clog2(GAP_LIMIT + 1);
  localparam int PW = $clog2(STROBE_CYCLES + 2);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two and the edge register are read by logic
  logic [3:0] sync1_reg, sync2_reg;
  logic       sck_prev_reg;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg    <= 4'h2;
      sync2_reg    <= 4'h2;
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= {serial_shift_clock, supply_low_sense, ext_wake_n, dialer_mode};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg[3];
    end
  end
  wire dialer_s = sync2_reg[0];
  wire wake_n_s = sync2_reg[1];
  wire low_s    = sync2_reg[2];
  wire sck_fall = sck_prev_reg & ~sync2_reg[3];

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon slave: one wait cycle, then the answer
  logic [31:0] ctrl_reg, ctrl_next, rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic [7:0]  status_bits;
  always_comb
  begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    ctrl_next  = ctrl_reg;
    rdata_next = rdata_reg;
    if (ack_next && avs_read)
      rdata_next = (avs_address == CTRL_OFFSET)   ? ctrl_reg :
                   (avs_address == STATUS_OFFSET) ? {24'h000000, status_bits} : 32'h00000000;
    if (ack_reg && avs_write && avs_address == CTRL_OFFSET)  // Lands at the answer edge
      ctrl_next = {31'h00000000, avs_writedata[CTRL_EN_BIT]};
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg  <= CTRL_RESET;
      rdata_reg <= 32'h00000000;
      ack_reg   <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Message checker
  msg_state_t  state_reg, state_next;
  logic [7:0]  sum_reg, sum_next, msg_left_reg, msg_left_next, par_left_reg, par_left_next;
  logic        multi_reg, multi_next, pkg_bad_reg, pkg_bad_next, sent_reg, sent_next;
  logic        window_reg, window_next, demod_prev_reg;
  logic [GW-1:0] gap_reg, gap_next;
  logic [5:0]  result_reg, result_next;   // done, pass, sum, gap, pkg, spare
  logic        push, push_final, err_now, call_start, final_end, hold_valid, sum_arrive;
  logic [7:0]  push_data, sum_add;
  logic        wake_rise;                 // Start of a wake event, from the supply section
  wire         gap_hit = (gap_reg == GW'(GAP_LIMIT));
  wire         checking = (state_reg inside {M_LEN, M_PTYPE, M_PLEN, M_BODY, M_SUM});

  always_comb
  begin
    state_next = state_reg; sum_next = sum_reg; msg_left_next = msg_left_reg;
    par_left_next = par_left_reg; multi_next = multi_reg; pkg_bad_next = pkg_bad_reg;
    sent_next = sent_reg; window_next = window_reg; result_next = result_reg;
    push = 1'b0; push_final = 1'b0; push_data = rx_byte; err_now = 1'b0;
    call_start = 1'b0; sum_arrive = 1'b0;
    sum_add = sum_reg + rx_byte;
    gap_next = (!checking || demod_bit != demod_prev_reg) ? '0 :
               (gap_hit ? gap_reg : gap_reg + GW'(1));
    case (state_reg)
      M_IDLE:
        if (rx_byte_valid && is_call_type(rx_byte) && ctrl_reg[CTRL_EN_BIT])
        begin
          state_next = M_LEN; window_next = 1'b1; call_start = 1'b1;
          sum_next = rx_byte; multi_next = (rx_byte[7:4] == TYPE_MULTI);
          pkg_bad_next = 1'b0; sent_next = 1'b0; result_next = 6'h00; push = 1'b1;
        end
      M_LEN, M_PTYPE, M_PLEN, M_BODY:
        if (rx_byte_valid)
        begin
          push = 1'b1; sum_next = sum_add;
          msg_left_next = msg_left_reg - 8'h01;
          if (state_reg == M_LEN)
          begin
            msg_left_next = rx_byte;
            state_next = (rx_byte == 8'h00) ? M_SUM : (multi_reg ? M_PTYPE : M_BODY);
          end
          else if (msg_left_reg == 8'h01)
          begin
            state_next = M_SUM;
            if (multi_reg && (state_reg == M_PTYPE ||
                (state_reg == M_PLEN && rx_byte != 8'h00) ||
                (state_reg == M_BODY && par_left_reg != 8'h01)))
              pkg_bad_next = 1'b1;
          end
          else if (state_reg == M_PTYPE)
            state_next = M_PLEN;
          else if (state_reg == M_PLEN)
          begin
            par_left_next = rx_byte;
            state_next = (rx_byte == 8'h00) ? M_PTYPE : M_BODY;
          end
          else if (multi_reg)
          begin
            par_left_next = par_left_reg - 8'h01;
            if (par_left_reg == 8'h01)
              state_next = M_PTYPE;
          end
        end
      M_SUM:
        if (rx_byte_valid)
        begin
          push = 1'b1; sum_next = sum_add; sum_arrive = 1'b1;
          result_next = {1'b1, (sum_add == 8'h00) && !pkg_bad_reg, sum_add != 8'h00,
                         1'b0, pkg_bad_reg, 1'b0};
          if (sum_add != 8'h00 || pkg_bad_reg)
            err_now = 1'b1;
          else
            state_next = M_DRAIN;
        end
      M_DRAIN:
      begin
        if (!sent_reg && !hold_valid)
        begin
          push = 1'b1; push_final = 1'b1; sent_next = 1'b1;
          push_data = result_reg[4] ? CHECK_PASS : CHECK_FAIL;
        end
        if (final_end)
        begin
          window_next = 1'b0;
          state_next = M_DONE;
        end
      end
      M_DONE:
        if (wake_rise)
          state_next = M_IDLE;
      default:
        state_next = M_IDLE;
    endcase
    if (checking && gap_hit)
    begin
      err_now = 1'b1; push = 1'b0; result_next = 6'b100100;
    end
    if (err_now)
    begin
      window_next = 1'b0; state_next = M_DONE;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= M_IDLE; sum_reg <= 8'h00; msg_left_reg <= 8'h00; par_left_reg <= 8'h00;
      multi_reg <= 1'b0; pkg_bad_reg <= 1'b0; sent_reg <= 1'b0; window_reg <= 1'b0;
      result_reg <= 6'h00; gap_reg <= '0; demod_prev_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next; sum_reg <= sum_next; msg_left_reg <= msg_left_next;
      par_left_reg <= par_left_next; multi_reg <= multi_next; pkg_bad_reg <= pkg_bad_next;
      sent_reg <= sent_next; window_reg <= window_next; result_reg <= result_next;
      gap_reg <= gap_next; demod_prev_reg <= demod_bit;
    end
  end
  // Open-drain window: drive low while active, else release to the pull-up
  assign output_window_n_o    = 1'b0;
  assign output_window_n_oe_n = ~window_reg;
  assign serial_data_oe_n     = ~window_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // One-unit hold buffer and shifter; units are 8 bits, or 4 in dialer mode
  logic [7:0] hold_reg, hold_next, shift_reg, shift_next;
  logic       hold_valid_reg, hold_valid_next, hold_fin_reg, hold_fin_next;
  logic       cur_fin_reg, cur_fin_next, unit_done;
  logic [3:0] bits_reg, bits_next;
  always_comb
  begin
    hold_next = hold_reg; hold_valid_next = hold_valid_reg; hold_fin_next = hold_fin_reg;
    shift_next = shift_reg; bits_next = bits_reg; cur_fin_next = cur_fin_reg;
    unit_done = 1'b0;
    if (bits_reg != 4'h0 && sck_fall)
    begin
      shift_next = {1'b0, shift_reg[7:1]};
      bits_next  = bits_reg - 4'h1;
      unit_done  = (bits_reg == 4'h1);
    end
    // Load only on a shift clock fall, so bit 0 stands a full half period before
    // the host's rising sample; loading mid-high would lose it to the next fall
    else if (bits_reg == 4'h0 && hold_valid_reg && sck_fall)
    begin
      shift_next = hold_reg; cur_fin_next = hold_fin_reg; hold_valid_next = 1'b0;
      bits_next  = dialer_s ? UNIT_DIALER : UNIT_HOST;
    end
    if (push)
    begin
      hold_next = push_data; hold_valid_next = 1'b1; hold_fin_next = push_final;
    end
    if (err_now)
    begin
      hold_valid_next = 1'b0; bits_next = 4'h0;
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      hold_reg <= 8'h00; hold_valid_reg <= 1'b0; hold_fin_reg <= 1'b0;
      shift_reg <= 8'h00; bits_reg <= 4'h0; cur_fin_reg <= 1'b0;
    end
    else
    begin
      hold_reg <= hold_next; hold_valid_reg <= hold_valid_next; hold_fin_reg <= hold_fin_next;
      shift_reg <= shift_next; bits_reg <= bits_next; cur_fin_reg <= cur_fin_next;
    end
  end
  assign hold_valid    = hold_valid_reg;
  assign serial_data_o = shift_reg[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe and irq pulses; at unit boundaries irq trails the strobe by one cycle, same width
  logic [PW-1:0] pcnt_reg, pcnt_next;
  logic          bound_reg, bound_next, pfin_reg, pfin_next, strobe_reg, strobe_next;
  logic          irq_reg, irq_next;
  always_comb
  begin
    pcnt_next = pcnt_reg; bound_next = bound_reg; pfin_next = pfin_reg;
    if (pcnt_reg != '0)
      pcnt_next = (pcnt_reg == PW'(STROBE_CYCLES + 1)) ? '0 : pcnt_reg + PW'(1);
    if (unit_done || call_start)
    begin
      pcnt_next = PW'(1); bound_next = unit_done; pfin_next = unit_done & cur_fin_reg;
    end
    strobe_next = !(bound_next && pcnt_next != '0 && pcnt_next <= PW'(STROBE_CYCLES));
    irq_next = !dialer_s && (bound_next ? (pcnt_next >= PW'(2))
                                        : (pcnt_next != '0 && pcnt_next <= PW'(STROBE_CYCLES)));
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pcnt_reg <= '0; bound_reg <= 1'b0; pfin_reg <= 1'b0;
      strobe_reg <= 1'b1; irq_reg <= 1'b0;
    end
    else
    begin
      pcnt_reg <= pcnt_next; bound_reg <= bound_next; pfin_reg <= pfin_next;
      strobe_reg <= strobe_next; irq_reg <= irq_next;
    end
  end
  assign final_end         = pfin_reg && bound_reg && pcnt_reg == PW'(STROBE_CYCLES);
  assign byte_ready_strobe = strobe_reg;
  assign host_irq_n_o      = 1'b0;
  assign host_irq_n_oe_n   = ~irq_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Supply-low detector window and latch
  logic det_reg, det_next, flag_reg, flag_next;
  wire  wake_any  = ring_detect | line_reversal | ~wake_n_s;
  assign wake_rise = wake_any & ~det_reg;
  always_comb
  begin
    det_next  = wake_any;
    flag_next = (det_reg && !wake_any) ? low_s : flag_reg;
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      det_reg  <= 1'b0;
      flag_reg <= 1'b0;
    end
    else
    begin
      det_reg  <= det_next;
      flag_reg <= flag_next;
    end
  end
  assign supply_low_flag = flag_reg;
  assign detector_enable = det_reg;
  // Status: window, done, pass, sum error, gap error, package error, flag, detector
  assign status_bits = {det_reg, flag_reg, result_reg[1], result_reg[2], result_reg[3],
                        result_reg[4], result_reg[5], window_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  window_tristate_a: assert property (output_window_n_oe_n |-> serial_data_oe_n)
    else $error("serial data driven outside window");
  error_release_a: assert property (err_now |=> output_window_n_oe_n && serial_data_oe_n)
    else $error("window not released after check error");
  sum_error_a: assert property (sum_arrive && sum_add != 8'h00 |=> !result_reg[4])
    else $error("bad checksum reported as pass");
  gap_error_a: assert property (checking && gap_hit |=> state_reg == M_DONE && result_reg[2])
    else $error("data gap not flagged");
  call_start_a: assert property ($rose(window_reg) |-> $past(rx_byte_valid && is_call_type(rx_byte)))
    else $error("window opened without valid type");
  irq_follow_a: assert property ($fell(byte_ready_strobe) && !dialer_s |=> $fell(host_irq_n_oe_n))
    else $error("irq did not follow strobe fall");
  strobe_first_a: assert property ($rose(byte_ready_strobe) && !dialer_s |-> !host_irq_n_oe_n ##1 host_irq_n_oe_n)
    else $error("irq not released one cycle after strobe");
  dialer_quiet_a: assert property (dialer_s && $past(dialer_s, 2) |-> host_irq_n_oe_n)
    else $error("irq driven in dialer mode");
  supply_latch_a: assert property ($fell(det_reg) |-> supply_low_flag == $past(low_s))
    else $error("supply flag not latched at wake end");
  final_release_a: assert property (final_end |=> output_window_n_oe_n)
    else $error("window held after final strobe");

  pass_msg_c: cover property (sum_arrive && sum_add == 8'h00 && !pkg_bad_reg);
  gap_err_c: cover property (checking && gap_hit);
  boundary_c: cover property ($fell(byte_ready_strobe) && !dialer_s);
  supply_c: cover property ($fell(det_reg) && low_s);

endmodule // callerid_check

// *** callerid_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module callerid_host_model
  import callerid_pkg::*;
(
  input  wire logic clock,
  input  wire logic dialer_mode,
  input  wire logic serial_data_o,
  input  wire logic window_line,
  input  wire logic irq_line,
  input  wire logic byte_ready_strobe,
  output logic      serial_shift_clock
);
  logic [7:0] bits_reg;
  logic [7:0] units[$];
  int         calls = 0;
  int         bounds = 0;
  int         bad = 0;
  int         irq_len = 0;
  int         stb_len = 0;
  // Shift clock runs only inside a frame and parks low between frames
  initial
  begin
    serial_shift_clock = 1'b0;
    forever
    begin
      wait (window_line === 1'b0);
      #62.5 serial_shift_clock = 1'b1;
      #62.5 serial_shift_clock = 1'b0;
    end
  end
  // Sample half a period after each shifting fall, well clear of the change
  always @(posedge serial_shift_clock)
    bits_reg <= {serial_data_o, bits_reg[7:1]};
  // A strobe closes a unit: keep the last 8 or 4 samples
  always @(negedge byte_ready_strobe)
    if (window_line === 1'b0)
      units.push_back(dialer_mode ? {4'h0, bits_reg[7:4]} : bits_reg);
  // Pulse widths and the strobe level seen at each interrupt
  always @(posedge clock)
  begin
    stb_len <= (byte_ready_strobe !== 1'b0) ? 0 : stb_len + 1;
    irq_len <= (irq_line !== 1'b0) ? 0 : irq_len + 1;
    if (byte_ready_strobe !== 1'b0 && stb_len != 0 && stb_len != STROBE_CYCLES)
      bad <= bad + 1;
    if (irq_line === 1'b0 && irq_len == 0)
    begin
      if (byte_ready_strobe === 1'b1) calls <= calls + 1;
      else bounds <= bounds + 1;
      if (dialer_mode) bad <= bad + 1;
    end
    if (irq_line !== 1'b0 && irq_len != 0)
      if (irq_len != STROBE_CYCLES || byte_ready_strobe !== 1'b1) bad <= bad + 1;
  end
endmodule // callerid_host_model

// *** tb_callerid_check.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_callerid_check;
  import callerid_pkg::*;
  localparam int GAP = 200;
  localparam int LIMIT = 90000;
  logic        clock, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic        dialer_mode, ext_wake_n, supply_low_sense, serial_shift_clock;
  logic        ring_detect, line_reversal, demod_bit, rx_byte_valid, gap_hold;
  logic [7:0]  rx_byte;
  logic        serial_data_o, serial_data_oe_n, output_window_n_o, output_window_n_oe_n;
  logic        byte_ready_strobe, host_irq_n_o, host_irq_n_oe_n;
  logic        supply_low_flag, detector_enable, window_line, irq_line;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Open-drain lines with board pull-ups
  assign window_line = output_window_n_oe_n ? 1'b1 : output_window_n_o;
  assign irq_line    = host_irq_n_oe_n ? 1'b1 : host_irq_n_o;
  ////////////////////////////////////////////////////////////////////////////////
  callerid_check #(.GAP_LIMIT(GAP)) callerid_check_inst (
    .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dialer_mode(dialer_mode),
    .ext_wake_n(ext_wake_n), .supply_low_sense(supply_low_sense),
    .serial_shift_clock(serial_shift_clock), .ring_detect(ring_detect),
    .line_reversal(line_reversal), .demod_bit(demod_bit), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .serial_data_o(serial_data_o),
    .serial_data_oe_n(serial_data_oe_n), .output_window_n_o(output_window_n_o),
    .output_window_n_oe_n(output_window_n_oe_n), .byte_ready_strobe(byte_ready_strobe),
    .host_irq_n_o(host_irq_n_o), .host_irq_n_oe_n(host_irq_n_oe_n),
    .supply_low_flag(supply_low_flag), .detector_enable(detector_enable));
  callerid_host_model callerid_host_model_inst (
    .clock(clock), .dialer_mode(dialer_mode), .serial_data_o(serial_data_o),
    .window_line(window_line), .irq_line(irq_line),
    .byte_ready_strobe(byte_ready_strobe), .serial_shift_clock(serial_shift_clock));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, demodulated bit activity and data tri-state watch
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (!gap_hold && cyc[2:0] == 3'h0) demod_bit <= ~demod_bit;
    if (output_window_n_oe_n === 1'b1 && serial_data_oe_n !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t data driven outside window", $time);
    end
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Error fields expected in the status word, one scenario kind each
  function automatic logic [3:0] exp_st(input int kind);
    case (kind)
      2: return 4'b0010;
      3: return 4'b1000;
      4: return 4'b0100;
      default: return 4'b0001;
    endcase
  endfunction
  task automatic check(input logic ok, input string what);
    n_tests++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Avalon master: request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge clock);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // One received byte, then room for it to be shifted out
  task automatic put(input logic [7:0] b, input int w);
    @(posedge clock);
    rx_byte <= b;
    rx_byte_valid <= 1'b1;
    @(posedge clock);
    rx_byte_valid <= 1'b0;
    repeat (w) @(posedge clock);
  endtask
  // Wake event of kind k with the supply comparator at level s
  task automatic wake(input int k, input logic s);
    @(posedge clock);
    supply_low_sense <= s;
    repeat (4) @(posedge clock);
    if (k == 0) ring_detect <= 1'b1;
    else if (k == 1) line_reversal <= 1'b1;
    else ext_wake_n <= 1'b0;
    repeat (k == 2 ? 1300 : 20) @(posedge clock);
    check(detector_enable === 1'b1, "detector off during wake");
    ring_detect <= 1'b0;
    line_reversal <= 1'b0;
    ext_wake_n <= 1'b1;
    repeat (6) @(posedge clock);
    check(supply_low_flag === s && detector_enable === 1'b0, "supply flag");
  endtask
  // Kind 0 single pass, 1 multi pass, 2 sum error, 3 package error, 4 gap
  task automatic run(input int kind, input logic dl);
    logic [7:0]  ty, sum, p, st;
    logic [7:0]  b[$];
    logic [31:0] rd;
    int          nu, nc, nb, m, lo, nsz;
    dialer_mode <= dl;
    seed = lfsr(seed);
    wake(kind % 3, seed[9]);
    p = 8'(seed[1:0]) + 8'h01;
    ty = {(kind == 0) ? TYPE_SINGLE : TYPE_MULTI, seed[7:4]};
    if (kind != 0)
    begin
      b.push_back(p + 8'(2 + (kind == 3)));
      b.push_back(seed[15:8]);
    end
    b.push_back(p);
    repeat (int'(p) + (kind == 3))
    begin
      seed = lfsr(seed);
      b.push_back(seed[23:16]);
    end
    sum = ty;
    foreach (b[i]) sum += b[i];
    sum = 8'h00 - sum + 8'(kind == 2);
    b.push_back(sum);
    nu = callerid_host_model_inst.units.size();
    nc = callerid_host_model_inst.calls;
    nb = callerid_host_model_inst.bounds;
    put(ty, 380);
    check(output_window_n_oe_n === 1'b0, "window not opened");
    for (int i = 0; i < b.size() - 1; i++) put(b[i], 380);
    if (kind == 4)
    begin
      gap_hold <= 1'b1;
      repeat (GAP + 6) @(posedge clock);
      check(output_window_n_oe_n === 1'b1, "no gap release");
      gap_hold <= 1'b0;
    end
    put(b[b.size() - 1], 2);
    m = b.size() + 1;
    if (kind >= 2)
      check(output_window_n_oe_n === 1'b1 && serial_data_oe_n === 1'b1, "no release");
    else
    begin
      lo = 0;
      for (int k = 0; k < 3000 && output_window_n_oe_n !== 1'b1; k++)
      begin
        @(posedge clock);
        lo = (byte_ready_strobe === 1'b0) ? 0 : lo + 1;
      end
      check(lo >= 1 && lo <= 2, "window release timing");
      nsz = callerid_host_model_inst.units.size();
      for (int i = 0; i < m; i++)
      begin
        st = (i == m - 1) ? CHECK_PASS : b[i];
        if (dl) st = {4'h0, st[3:0]};
        check(callerid_host_model_inst.units[nsz - m + i] === st, "serial unit");
      end
      check(callerid_host_model_inst.calls - nc == (dl ? 0 : 1), "call irq");
      check(callerid_host_model_inst.bounds - nb == (dl ? 0 : nsz - nu), "byte irq");
    end
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    check(rd[5:2] === exp_st(kind) && rd[0] === 1'b0, "status fields");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: registers, refusals, then random messages in both modes
  initial
  begin
    logic [31:0] rd;
    rst = 1'b1;
    {avs_read, avs_write, rx_byte_valid, ring_detect, line_reversal} = 5'h00;
    {dialer_mode, supply_low_sense, demod_bit, gap_hold} = 4'h0;
    ext_wake_n = 1'b1;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    rx_byte = 8'h00;
    seed = 32'hE068F35D;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, CTRL_OFFSET, 32'h0, rd);
    check(rd === CTRL_RESET, "control reset value");
    bus(1'b0, STATUS_OFFSET, 32'h0, rd);
    check(rd === 32'h0, "status reset value");
    bus(1'b1, 4'h8, 32'hFFFFFFFF, rd);
    bus(1'b0, 4'h8, 32'h0, rd);
    check(rd === 32'h0, "unmapped read");
    wake(0, 1'b1);
    put(8'h40, 20);
    check(output_window_n_oe_n === 1'b1, "non-call type accepted");
    bus(1'b1, CTRL_OFFSET, 32'h0, rd);
    wake(1, 1'b0);
    put(8'h81, 20);
    check(output_window_n_oe_n === 1'b1, "disabled check opened window");
    bus(1'b1, CTRL_OFFSET, 32'h1, rd);
    for (int i = 0; i < 10; i++) run(i % 5, i >= 5);
    check(callerid_host_model_inst.bad == 0, "strobe or irq timing");
    conclude();
  end
endmodule // tb_callerid_check
